// *** hw/rdlc_pkg.sv ***
// package for the demodulator loop and calibration scheduling configuration block
// assumes an 8-bit register port and single-cycle event pulses from the radio control logic
package rdlc_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 16'hDF10;
  localparam logic [ADDR_W-1:0] ADDR_SM_CFG   = 16'hDF14;
  localparam logic [ADDR_W-1:0] ADDR_FOC_CFG  = 16'hDF15;
  localparam logic [ADDR_W-1:0] ADDR_BS_CFG   = 16'hDF16;

  // values after reset
  localparam logic [DATA_W-1:0] RST_SM_CFG    = 8'h04;
  localparam logic [DATA_W-1:0] RST_FOC_CFG   = 8'h76;
  localparam logic [DATA_W-1:0] RST_BS_CFG    = 8'h6C;
  localparam logic [DATA_W-1:0] RD_UNMAPPED   = 8'h00;

  // radio_state_machine_config fields
  localparam int SM_CAL_HI    = 5;
  localparam int SM_CAL_LO    = 4;
  localparam int SM_RSV_HI    = 3;
  localparam int SM_RSV_LO    = 0;
  localparam logic [DATA_W-1:0] SM_WR_MASK  = 8'h3F;

  // freq_offset_comp_config fields
  localparam int FOC_RSV6     = 6;
  localparam int FOC_GATE     = 5;
  localparam int FOC_PRE_HI   = 4;
  localparam int FOC_PRE_LO   = 3;
  localparam int FOC_POST     = 2;
  localparam int FOC_LIM_HI   = 1;
  localparam int FOC_LIM_LO   = 0;
  localparam logic [DATA_W-1:0] FOC_WR_MASK = 8'h7F;

  // bit_sync_config fields
  localparam int BS_KI_HI     = 7;
  localparam int BS_KI_LO     = 6;
  localparam int BS_KP_HI     = 5;
  localparam int BS_KP_LO     = 4;
  localparam int CLKREC_INT_GAIN_POSTSYNC   = 3;
  localparam int CLKREC_PROP_GAIN_POSTSYNC   = 2;
  localparam int BS_LIM_HI    = 1;
  localparam int BS_LIM_LO    = 0;

  // status register fields
  localparam int ST_POST      = 0;
  localparam int ST_FROZEN    = 1;
  localparam int ST_CNT_LO    = 2;
  localparam int ST_CNT_HI    = 3;
  localparam int ST_WAIT_CS   = 4;

  // calibration schedule
  typedef enum logic [1:0] {
    CAL_NEVER      = 2'h0,
    CAL_ON_START   = 2'h1,
    CAL_ON_RETURN  = 2'h2,
    CAL_EVERY_NTH  = 2'h3
  } rdlc_cal_mode_t;

  localparam int CAL_EVERY_N = 4;

  // demodulator loop phase, one-hot
  typedef enum logic [2:0] {
    PH_WAIT_CS  = 3'h1,
    PH_PRESYNC  = 3'h2,
    PH_POSTSYNC = 3'h4
  } rdlc_phase_t;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } rdlc_bus_req_t;

  // frequency and integral gains in half units of the base gain, proportional gain in base units, limits in units of the smallest step
  typedef struct packed {
    logic [3:0] freq_gain_half_k;
    logic [2:0] freq_limit_eighths;
    logic [3:0] clk_int_gain_half_ki;
    logic [2:0] clk_prop_gain_kp;
    logic [2:0] rate_limit_steps;
    logic       freq_comp_en;
    logic       rate_comp_en;
    logic       loops_frozen;
  } rdlc_loop_ctl_t;

endpackage

// *** hw/rdlc_cal_sched.sv ***
// synthesizer calibration scheduler: turns radio state events into calibrate pulses
// assumes event inputs are one-cycle pulses from logic on sys_clk
`timescale 1ns/1ns
module rdlc_cal_sched
  import rdlc_pkg::*;
#(
  parameter int EVERY_N = CAL_EVERY_N
) (
  input  wire logic         sys_clk,          // system clock
  input  wire logic         reset_n,          // synchronous reset, active low
  input  wire logic [1:0]   cal_mode,         // synth_cal_schedule field
  input  wire logic         idle_to_active,   // idle to rx, tx or tx_synth_on_state
  input  wire logic         auto_return_idle, // automatic return from rx or tx to idle
  input  wire logic         manual_calibrate_strobe, // software calibrate command
  output logic              cal_start,        // one-cycle calibrate request
  output logic [1:0]        return_count      // returns counted in every-nth mode
);

  localparam logic [1:0] LAST_COUNT = 2'(EVERY_N - 1);

  logic next_cal;
  logic nth_hit;

  assign nth_hit = (return_count == LAST_COUNT);

  always_comb begin
    next_cal = manual_calibrate_strobe;
    case (rdlc_cal_mode_t'(cal_mode))
      CAL_NEVER: begin
        next_cal = manual_calibrate_strobe;
      end
      CAL_ON_START: begin
        if (idle_to_active) begin
          next_cal = 1'b1;
        end
      end
      CAL_ON_RETURN: begin
        if (auto_return_idle) begin
          next_cal = 1'b1;
        end
      end
      CAL_EVERY_NTH: begin
        if (auto_return_idle && nth_hit) begin
          next_cal = 1'b1;
        end
      end
      default: begin
        next_cal = manual_calibrate_strobe;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cal_start <= 1'b0;
    end else begin
      cal_start <= next_cal;
    end
  end

  // counter only runs in every-nth mode so a mode switch starts a fresh count
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      return_count <= 2'h0;
    end else if (cal_mode != 2'(CAL_EVERY_NTH)) begin
      return_count <= 2'h0;
    end else if (auto_return_idle) begin
      return_count <= nth_hit ? 2'h0 : return_count + 2'h1;
    end
  end

endmodule

// *** hw/rdlc_top.sv ***
// configuration registers and loop control for the demodulator feedback loops
// and the synthesizer calibration schedule of a packet radio
// assumes radio events (state changes, carrier sense, sync found) are pulses or
// levels from logic on sys_clk, and an 8-bit register port with one-cycle strobes
//
// Contract
// - With schedule 00 the synthesizer is calibrated only on the manual calibrate command.
// - With schedule 01 a calibration starts on every move from idle to rx, tx or tx synth on.
// - With schedule 10 a calibration starts on every automatic return from rx or tx to idle.
// - With schedule 11 automatic returns to idle are counted and every fourth one calibrates.
// - With the gate bit set both loops stay frozen until carrier sense goes high; here a sync word found while waiting also ends the freeze.
// - Pre-sync frequency loop gain is K, 2K, 3K or 4K for codes 00 to 11, reset 10.
// - Post-sync frequency loop gain is the pre-sync gain when the bit is 0, else K/2.
// - Frequency compensation saturates at 0, BW/8, BW/4 or BW/2; zero disables it.
// - Pre-sync clock recovery integral gain is 1 to 4 times base for codes 00 to 11, reset 01.
// - Pre-sync clock recovery proportional gain is 1 to 4 times base, reset 10.
// - Post-sync integral gain is the pre-sync one when the bit is 0, else half the base.
// - Post-sync proportional gain is the pre-sync one when the bit is 0, else the base.
// - Data rate compensation saturates at 0, 3.125, 6.25 or 12.5 percent; zero disables it.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
module rdlc_top
  import rdlc_pkg::*;
#(
  parameter int CAL_N = CAL_EVERY_N
) (
  input  wire logic                 sys_clk,                 // 100 MHz system clock
  input  wire logic                 reset_n,                 // synchronous reset, active low
  input  wire logic [ADDR_W-1:0]    reg_addr,                // register address
  input  wire logic [DATA_W-1:0]    reg_wdata,               // register write data
  input  wire logic                 reg_wr,                  // write strobe
  input  wire logic                 reg_rd,                  // read strobe
  output logic      [DATA_W-1:0]    reg_rdata,               // read data, cycle after reg_rd
  input  wire logic                 idle_to_active,          // idle to rx, tx or tx_synth_on_state
  input  wire logic                 auto_return_idle,        // automatic rx or tx to idle
  input  wire logic                 manual_calibrate_strobe, // calibrate command strobe
  input  wire logic                 rx_start,                // new reception begins
  input  wire logic                 carrier_sense,           // carrier sense level
  input  wire logic                 sync_detect,             // sync word found pulse
  output logic                      cal_start,               // calibrate synthesizer pulse
  output rdlc_loop_ctl_t            loop_ctl                 // loop gains, limits, freeze
);

  rdlc_bus_req_t  req;
  rdlc_phase_t    phase;
  rdlc_phase_t    next_phase;

  logic [DATA_W-1:0] sm_cfg;
  logic [DATA_W-1:0] foc_cfg;
  logic [DATA_W-1:0] bs_cfg;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        return_count;

  logic       post_active;
  logic       frozen;
  logic [1:0] synth_cal_schedule;
  logic       loops_wait_carrier_gate;
  logic [1:0] freq_loop_gain_presync;
  logic       freq_loop_gain_postsync;
  logic [1:0] freq_loop_saturation;
  logic [1:0] clkrec_int_gain_presync;
  logic [1:0] clkrec_prop_gain_presync;
  logic       clkrec_int_gain_postsync;
  logic       clkrec_prop_gain_postsync;
  logic [1:0] rate_offset_saturation;

  logic [3:0] freq_pre_half;
  logic [3:0] int_pre_half;
  logic [2:0] prop_pre;

  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  // field views
  assign synth_cal_schedule        = sm_cfg[SM_CAL_HI:SM_CAL_LO];
  assign loops_wait_carrier_gate   = foc_cfg[FOC_GATE];
  assign freq_loop_gain_presync    = foc_cfg[FOC_PRE_HI:FOC_PRE_LO];
  assign freq_loop_gain_postsync   = foc_cfg[FOC_POST];
  assign freq_loop_saturation      = foc_cfg[FOC_LIM_HI:FOC_LIM_LO];
  assign clkrec_int_gain_presync   = bs_cfg[BS_KI_HI:BS_KI_LO];
  assign clkrec_prop_gain_presync  = bs_cfg[BS_KP_HI:BS_KP_LO];
  assign clkrec_int_gain_postsync  = bs_cfg[CLKREC_INT_GAIN_POSTSYNC];
  assign clkrec_prop_gain_postsync = bs_cfg[CLKREC_PROP_GAIN_POSTSYNC];
  assign rate_offset_saturation    = bs_cfg[BS_LIM_HI:BS_LIM_LO];

  // register writes; unused top bits of the first two registers read as zero.
  // reserved bits are stored as written, software is expected to keep them as required
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sm_cfg <= RST_SM_CFG;
    end else if (req.wr && req.addr == ADDR_SM_CFG) begin
      sm_cfg <= req.wdata & SM_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      foc_cfg <= RST_FOC_CFG;
    end else if (req.wr && req.addr == ADDR_FOC_CFG) begin
      foc_cfg <= req.wdata & FOC_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bs_cfg <= RST_BS_CFG;
    end else if (req.wr && req.addr == ADDR_BS_CFG) begin
      bs_cfg <= req.wdata;
    end
  end

  // read-only status of the loop controller and the calibration counter
  always_comb begin
    status                        = 8'h00;
    status[ST_POST]               = (phase == PH_POSTSYNC);
    status[ST_FROZEN]             = frozen;
    status[ST_CNT_HI:ST_CNT_LO]   = return_count;
    status[ST_WAIT_CS]            = (phase == PH_WAIT_CS);
  end

  always_comb begin
    next_rdata = RD_UNMAPPED;
    case (req.addr)
      ADDR_STATUS: begin
        next_rdata = status;
      end
      ADDR_SM_CFG: begin
        next_rdata = sm_cfg;
      end
      ADDR_FOC_CFG: begin
        next_rdata = foc_cfg;
      end
      ADDR_BS_CFG: begin
        next_rdata = bs_cfg;
      end
      default: begin
        next_rdata = RD_UNMAPPED;
      end
    endcase
  end

  // read data only stands in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  rdlc_cal_sched #(
    .EVERY_N                 (CAL_N)
  ) u_cal_sched (
    .sys_clk                 (sys_clk),
    .reset_n                 (reset_n),
    .cal_mode                (synth_cal_schedule),
    .idle_to_active          (idle_to_active),
    .auto_return_idle        (auto_return_idle),
    .manual_calibrate_strobe (manual_calibrate_strobe),
    .cal_start               (cal_start),
    .return_count            (return_count)
  );

  // loop phase; a new reception outranks a sync pulse in the same cycle
  always_comb begin
    next_phase = phase;
    if (rx_start) begin
      next_phase = loops_wait_carrier_gate ? PH_WAIT_CS : PH_PRESYNC;
    end else begin
      case (phase)
        PH_WAIT_CS: begin
          if (sync_detect) begin
            next_phase = PH_POSTSYNC;
          end else if (carrier_sense || !loops_wait_carrier_gate) begin
            next_phase = PH_PRESYNC;
          end
        end
        PH_PRESYNC: begin
          if (sync_detect) begin
            next_phase = PH_POSTSYNC;
          end
        end
        PH_POSTSYNC: begin
          next_phase = PH_POSTSYNC;
        end
        default: begin
          next_phase = PH_PRESYNC;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase <= PH_PRESYNC;
    end else begin
      phase <= next_phase;
    end
  end

  // freeze releases in the same cycle carrier sense rises, not one later
  assign frozen = loops_wait_carrier_gate && (phase == PH_WAIT_CS) && !carrier_sense;

  // post gains take effect combinationally with the sync pulse itself
  assign post_active = !rx_start && ((phase == PH_POSTSYNC) || sync_detect);

  // gains in half-base units so K/2 and Ki/2 stay integers
  assign freq_pre_half = {1'b0, freq_loop_gain_presync, 1'b0} + 4'h2;
  assign int_pre_half  = {1'b0, clkrec_int_gain_presync, 1'b0} + 4'h2;
  assign prop_pre      = {1'b0, clkrec_prop_gain_presync} + 3'h1;

  always_comb begin
    loop_ctl = '0;
    loop_ctl.freq_gain_half_k = freq_pre_half;
    if (post_active && freq_loop_gain_postsync) begin
      loop_ctl.freq_gain_half_k = 4'h1;
    end
    loop_ctl.clk_int_gain_half_ki = int_pre_half;
    if (post_active && clkrec_int_gain_postsync) begin
      loop_ctl.clk_int_gain_half_ki = 4'h1;
    end
    loop_ctl.clk_prop_gain_kp = prop_pre;
    if (post_active && clkrec_prop_gain_postsync) begin
      loop_ctl.clk_prop_gain_kp = 3'h1;
    end
    case (freq_loop_saturation)
      2'h0: loop_ctl.freq_limit_eighths = 3'h0;
      2'h1: loop_ctl.freq_limit_eighths = 3'h1;
      2'h2: loop_ctl.freq_limit_eighths = 3'h2;
      2'h3: loop_ctl.freq_limit_eighths = 3'h4;
      default: loop_ctl.freq_limit_eighths = 3'h0;
    endcase
    case (rate_offset_saturation)
      2'h0: loop_ctl.rate_limit_steps = 3'h0;
      2'h1: loop_ctl.rate_limit_steps = 3'h1;
      2'h2: loop_ctl.rate_limit_steps = 3'h2;
      2'h3: loop_ctl.rate_limit_steps = 3'h4;
      default: loop_ctl.rate_limit_steps = 3'h0;
    endcase
    loop_ctl.freq_comp_en = (freq_loop_saturation != 2'h0);
    loop_ctl.rate_comp_en = (rate_offset_saturation != 2'h0);
    loop_ctl.loops_frozen = frozen;
  end

endmodule

// *** verif/rdlc_top_props.sv ***
// port-level assertions for the loop and calibration configuration block
// assumes it is bound to rdlc_top and shares its single clock and reset
`timescale 1ns/1ns
module rdlc_top_props
  import rdlc_pkg::*;
#(
  parameter int CAL_N = CAL_EVERY_N
) (
  input wire logic                 sys_clk,                 // clock
  input wire logic                 reset_n,                 // reset, active low
  input wire logic [ADDR_W-1:0]    reg_addr,                // address
  input wire logic [DATA_W-1:0]    reg_wdata,               // write data
  input wire logic                 reg_wr,                  // write strobe
  input wire logic                 reg_rd,                  // read strobe
  input wire logic [DATA_W-1:0]    reg_rdata,               // read data
  input wire logic                 idle_to_active,          // start event
  input wire logic                 auto_return_idle,        // return event
  input wire logic                 manual_calibrate_strobe, // manual command
  input wire logic                 rx_start,                // reception start
  input wire logic                 carrier_sense,           // carrier sense
  input wire logic                 sync_detect,             // sync found
  input wire logic                 cal_start,               // calibrate pulse
  input wire rdlc_loop_ctl_t       loop_ctl                 // loop settings
);
  wire any_ev = manual_calibrate_strobe || idle_to_active || auto_return_idle;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // a write in the sync cycle would legally change gains a cycle later
  sequence s_sync_taken;
    sync_detect && !rx_start && !reg_wr;
  endsequence

  sequence s_post_kept;
    $stable(loop_ctl.freq_gain_half_k) && $stable(loop_ctl.clk_int_gain_half_ki) && $stable(loop_ctl.clk_prop_gain_kp);
  endsequence

  chk_manual_cal: assert property (manual_calibrate_strobe |=> cal_start)
    else $error("no calibrate pulse after manual command");
  chk_cal_cause: assert property (cal_start |-> $past(any_ev))
    else $error("calibrate pulse without an event");
  chk_freq_en: assert property (loop_ctl.freq_comp_en == (loop_ctl.freq_limit_eighths != 3'h0))
    else $error("frequency compensation enable wrong");
  chk_rate_en: assert property (loop_ctl.rate_comp_en == (loop_ctl.rate_limit_steps != 3'h0))
    else $error("rate compensation enable wrong");
  chk_limit_codes: assert property (loop_ctl.freq_limit_eighths inside {0, 1, 2, 4} && loop_ctl.rate_limit_steps inside {0, 1, 2, 4})
    else $error("saturation limit outside legal set");
  chk_gain_codes: assert property (loop_ctl.freq_gain_half_k inside {1, 2, 4, 6, 8} && loop_ctl.clk_int_gain_half_ki inside {1, 2, 4, 6, 8} && loop_ctl.clk_prop_gain_kp inside {1, 2, 3, 4})
    else $error("loop gain outside legal set");
  chk_post_hold: assert property (s_sync_taken |=> rx_start or s_post_kept)
    else $error("post sync gains not held");
  chk_frozen_cs: assert property (loop_ctl.loops_frozen |-> !carrier_sense)
    else $error("loops frozen while carrier sense high");
  chk_frz_cause: assert property ($rose(loop_ctl.loops_frozen) |-> $past(rx_start) || $past(reg_wr) || $fell(carrier_sense))
    else $error("loops froze without a cause");
endmodule

// *** verif/rdlc_top_tb_top.sv ***
// self-checking bench for the loop and calibration configuration block
// assumes the checker module is compiled alongside and bound below
`timescale 1ns/1ns
module rdlc_top_tb_top;
  import rdlc_pkg::*;
  localparam int N_CAL = 4;
  logic                 sys_clk, reset_n, reg_wr, reg_rd, idle_to_active, auto_return_idle;
  logic                 manual_calibrate_strobe, rx_start, carrier_sense, sync_detect, cal_start;
  logic [ADDR_W-1:0]    reg_addr;
  logic [DATA_W-1:0]    reg_wdata, reg_rdata, got;
  rdlc_loop_ctl_t       loop_ctl;
  int                   err_count, n_tests, cycles;

  rdlc_top #(.CAL_N(N_CAL)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .idle_to_active(idle_to_active), .auto_return_idle(auto_return_idle),
    .manual_calibrate_strobe(manual_calibrate_strobe), .rx_start(rx_start),
    .carrier_sense(carrier_sense), .sync_detect(sync_detect), .cal_start(cal_start), .loop_ctl(loop_ctl));

  task automatic cmp_reg(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmp_bit(string what, logic exp, logic seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic cmp_ctl(string what, rdlc_loop_ctl_t exp, rdlc_loop_ctl_t seen);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task automatic pulse(int sel);
    @(posedge sys_clk);
    case (sel)
      0: idle_to_active <= 1'b1;
      1: auto_return_idle <= 1'b1;
      2: manual_calibrate_strobe <= 1'b1;
      default: rx_start <= 1'b1;
    endcase
    @(posedge sys_clk);
    {idle_to_active, auto_return_idle, manual_calibrate_strobe, rx_start} <= 4'h0;
    #1;
  endtask

  function automatic rdlc_loop_ctl_t exp_ctl(int c, logic post);
    rdlc_loop_ctl_t e;
    int             lim;
    lim = (c == 3) ? 4 : c;
    e.freq_gain_half_k     = post ? 4'h1 : 4'(2 * c + 2);
    e.freq_limit_eighths   = 3'(lim);
    e.clk_int_gain_half_ki = post ? 4'h1 : 4'(2 * c + 2);
    e.clk_prop_gain_kp     = post ? 3'h1 : 3'(c + 1);
    e.rate_limit_steps     = 3'(lim);
    e.freq_comp_en         = (c != 0);
    e.rate_comp_en         = (c != 0);
    e.loops_frozen         = 1'b0;
    return e;
  endfunction

  task automatic t_regs();
    cmp_ctl("reset loop ctl", rdlc_loop_ctl_t'{4'h6, 3'h2, 4'h4, 3'h3, 3'h0, 1'b1, 1'b0, 1'b0}, loop_ctl);
    rd_reg(ADDR_SM_CFG);
    cmp_reg("sm cfg reset", 8'h04, got);
    @(posedge sys_clk);
    #1 cmp_reg("rdata after read", 8'h00, reg_rdata);
    rd_reg(ADDR_FOC_CFG);
    cmp_reg("foc cfg reset", 8'h76, got);
    rd_reg(ADDR_BS_CFG);
    cmp_reg("bs cfg reset", 8'h6C, got);
    rd_reg(16'hDF20);
    cmp_reg("unmapped", 8'h00, got);
    wr_reg(ADDR_SM_CFG, 8'hC4);
    rd_reg(ADDR_SM_CFG);
    cmp_reg("sm cfg unused bits", 8'h04, got);
    wr_reg(ADDR_FOC_CFG, 8'h3F);
    rd_reg(ADDR_FOC_CFG);
    cmp_reg("foc cfg write", 8'h3F, got);
  endtask

  task automatic t_cal();
    for (int m = 0; m < 4; m++) begin
      wr_reg(ADDR_SM_CFG, {2'b00, 2'(m), 4'h4});
      pulse(2);
      cmp_bit("manual cal", 1'b1, cal_start);
      pulse(0);
      cmp_bit("start cal", m == 1, cal_start);
      // eight returns show the every-nth count wrapping, not just firing once
      for (int i = 0; i < 2 * N_CAL; i++) begin
        pulse(1);
        cmp_bit("return cal", (m == 2) || (m == 3 && i % N_CAL == N_CAL - 1), cal_start);
        if (m == 3 && i == 1) begin
          rd_reg(ADDR_STATUS);
          cmp_reg("return count", 8'h08, got);
        end
      end
    end
  endtask

  task automatic t_gate();
    wr_reg(ADDR_FOC_CFG, 8'h36);
    pulse(3);
    repeat (3) begin
      @(posedge sys_clk);
      #1 cmp_bit("frozen waiting", 1'b1, loop_ctl.loops_frozen);
    end
    rd_reg(ADDR_STATUS);
    cmp_reg("status waiting", 8'h12, got);
    @(posedge sys_clk);
    carrier_sense <= 1'b1;
    #1 cmp_bit("released by carrier", 1'b0, loop_ctl.loops_frozen);
    @(posedge sys_clk);
    carrier_sense <= 1'b0;
    #1 cmp_bit("stays released", 1'b0, loop_ctl.loops_frozen);
    // sync found while still waiting for carrier goes straight to post gains
    pulse(3);
    @(posedge sys_clk);
    sync_detect <= 1'b1;
    @(posedge sys_clk);
    sync_detect <= 1'b0;
    #1 cmp_bit("sync ends wait", 1'b0, loop_ctl.loops_frozen);
    rd_reg(ADDR_STATUS);
    cmp_reg("status postsync", 8'h01, got);
    @(posedge sys_clk);
    {rx_start, sync_detect} <= 2'b11;
    #1 cmp_ctl("rx start beats sync", rdlc_loop_ctl_t'{4'h6, 3'h2, 4'h4, 3'h3, 3'h0, 1'b1, 1'b0, 1'b0}, loop_ctl);
    @(posedge sys_clk);
    {rx_start, sync_detect} <= 2'b00;
    #1 cmp_bit("waiting again", 1'b1, loop_ctl.loops_frozen);
  endtask

  task automatic t_gains();
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 2; p++) begin
        wr_reg(ADDR_FOC_CFG, {3'b000, 2'(c), 1'(p), 2'(c)});
        wr_reg(ADDR_BS_CFG, {2'(c), 2'(c), 1'(p), 1'(p), 2'(c)});
        pulse(3);
        cmp_ctl("presync", exp_ctl(c, 1'b0), loop_ctl);
        @(posedge sys_clk);
        sync_detect <= 1'b1;
        #1 cmp_ctl("sync cycle", exp_ctl(c, 1'(p)), loop_ctl);
        @(posedge sys_clk);
        sync_detect <= 1'b0;
        #1 cmp_ctl("postsync", exp_ctl(c, 1'(p)), loop_ctl);
        pulse(3);
        cmp_ctl("reverted", exp_ctl(c, 1'b0), loop_ctl);
      end
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d, checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // the whole run is a few hundred cycles, so this only trips on a hang
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    {reset_n, reg_wr, reg_rd, idle_to_active, auto_return_idle} = 5'h00;
    {manual_calibrate_strobe, rx_start, carrier_sense, sync_detect} = 4'h0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    err_count = 0;
    n_tests = 0;
    cycles = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    t_regs();
    t_cal();
    t_gate();
    t_gains();
    tally_and_finish();
  end
endmodule

bind rdlc_top rdlc_top_props #(.CAL_N(CAL_N)) u_props (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .idle_to_active(idle_to_active), .auto_return_idle(auto_return_idle),
  .manual_calibrate_strobe(manual_calibrate_strobe), .rx_start(rx_start), .carrier_sense(carrier_sense),
  .sync_detect(sync_detect), .cal_start(cal_start), .loop_ctl(loop_ctl));
